// ===== core/scc_pkg.sv
// constants, types and decode helpers for the smbus clock control block
`default_nettype none
package scc_pkg;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_OUT_EN = 8'h00;
  localparam logic [7:0] IDX_SPREAD = 8'h01;
  localparam logic [7:0] IDX_EDGE = 8'h02;
  localparam logic [7:0] IDX_REF = 8'h03;
  localparam int NUM_REGS = 4;
  localparam logic [7:0] LAST_IDX = 8'h03;
  // ----------------------------------------------------------------
  // reset values and writable bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OUT_EN = 8'hDD;
  localparam logic [7:0] RST_SPREAD = 8'h02;
  localparam logic [7:0] RST_EDGE = 8'hDD;
  localparam logic [7:0] RST_REF = 8'h50;
  localparam logic [7:0] MASK_OUT_EN = 8'hDD;
  localparam logic [7:0] MASK_SPREAD = 8'h3B;
  localparam logic [7:0] MASK_EDGE = 8'hDD;
  localparam logic [7:0] MASK_REF = 8'hF0;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SPREAD_SW_CTRL_BIT = 5;
  localparam int SPREAD_SW_HI = 4;
  localparam int SPREAD_SW_LO = 3;
  localparam int AMP_HI = 1;
  localparam int AMP_LO = 0;
  localparam int REF_SLEW_HI = 7;
  localparam int REF_SLEW_LO = 6;
  localparam int REF_WOL_BIT = 5;
  localparam int REF_OE_BIT = 4;
  // ----------------------------------------------------------------
  // bus constants
  // ----------------------------------------------------------------
  localparam logic [7:0] READ_BLOCK_COUNT = 8'h08;
  localparam logic [6:0] TARGET_ADDR_SEL0 = 7'h68;
  localparam logic [6:0] TARGET_ADDR_SEL1 = 7'h6A;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam int NUM_DIFF = 6;
  localparam int PIN_SYNC_W = 12;
  // bus lines idle high; power good and the straps count as low until sampled
  localparam logic [PIN_SYNC_W-1:0] SYNC_IDLE = 12'hC00;
  // ----------------------------------------------------------------
  // disable states and machine encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] STOP_LOW = 2'h0;
  localparam logic [1:0] STOP_FLOAT = 2'h1;
  localparam logic [1:0] STOP_TRUE_HI = 2'h2;
  localparam logic [1:0] STOP_COMP_HI = 2'h3;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_TXACK = 5'h10
  } scc_state_t;
  typedef enum logic [3:0] {
    PH_ADDR = 4'h1,
    PH_INDEX = 4'h2,
    PH_COUNT = 4'h4,
    PH_DATA = 4'h8
  } scc_phase_t;
  // per-output bits sit at 7,6,4,3,2,0 of both the enable and edge rate bytes
  function automatic logic [5:0] scc_diff_bits(input logic [7:0] b);
    return {b[7], b[6], b[4], b[3], b[2], b[0]};
  endfunction
endpackage
`default_nettype wire

// ===== core/scc_reg_bank.sv
// control byte storage and the output controls they steer
`default_nettype none
module scc_reg_bank (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_idx,
  output logic [7:0] rd_data,
  input wire logic [1:0] spread_pin_readback,
  input wire logic [5:0] diff_pin_enable,
  input wire logic [1:0] stop_state_field,
  output logic [5:0] diff_running,
  output logic [5:0] diff_true_level,
  output logic [5:0] diff_comp_level,
  output logic [5:0] diff_float,
  output logic [5:0] diff_edge_rate,
  output logic [1:0] diff_amplitude,
  output logic [1:0] spread_amount,
  output logic [1:0] ref_slew,
  output logic ref_enable,
  output logic ref_wake_on_lan
);
  import scc_pkg::*;
  localparam logic [7:0] REG_RST [0:NUM_REGS-1] = '{RST_OUT_EN, RST_SPREAD, RST_EDGE, RST_REF};
  localparam logic [7:0] REG_MASK [0:NUM_REGS-1] = '{MASK_OUT_EN, MASK_SPREAD, MASK_EDGE, MASK_REF};

  logic [7:0] regs [0:NUM_REGS-1];
  logic [7:0] next_regs [0:NUM_REGS-1];
  logic [7:0] next_rd_data;
  logic [5:0] next_running, next_true, next_comp, next_float;
  logic [1:0] next_spread;
  logic [5:0] ovr;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NUM_REGS; i++)
    begin
      next_regs[i] = regs[i];
    end
    // indices past the bank are acknowledged on the bus but store nothing
    if (wr_en && (wr_idx <= LAST_IDX))
    begin
      next_regs[wr_idx[1:0]] = wr_data & REG_MASK[wr_idx[1:0]]; // RL3
    end
    case (rd_idx)
      IDX_OUT_EN: next_rd_data = regs[0];
      IDX_SPREAD: next_rd_data = {spread_pin_readback, regs[1][5:0]}; // RL11
      IDX_EDGE: next_rd_data = regs[2];
      IDX_REF: next_rd_data = regs[3];
      default: next_rd_data = 8'h00;
    endcase
    ovr = scc_diff_bits(regs[0]);
    for (int i = 0; i < NUM_DIFF; i++)
    begin
      next_running[i] = ovr[i] & diff_pin_enable[i]; // RL9
      next_true[i] = 1'b0;
      next_comp[i] = 1'b0;
      next_float[i] = 1'b0;
      if (!next_running[i])
      begin
        case (stop_state_field) // RL10
          STOP_LOW: next_true[i] = 1'b0;
          STOP_FLOAT: next_float[i] = 1'b1;
          STOP_TRUE_HI: next_true[i] = 1'b1;
          STOP_COMP_HI: next_comp[i] = 1'b1;
          default: next_float[i] = 1'b0;
        endcase
      end
    end
    // software select counts only once software control is on
    if (regs[1][SPREAD_SW_CTRL_BIT])
    begin
      next_spread = regs[1][SPREAD_SW_HI:SPREAD_SW_LO]; // RL12 RL13
    end
    else
    begin
      next_spread = spread_pin_readback; // RL12
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs[i] <= REG_RST[i];
      end
      rd_data <= 8'h00;
      diff_running <= 6'h00;
      diff_true_level <= 6'h00;
      diff_comp_level <= 6'h00;
      diff_float <= 6'h00;
      spread_amount <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs[i] <= next_regs[i];
      end
      rd_data <= next_rd_data;
      diff_running <= next_running;
      diff_true_level <= next_true;
      diff_comp_level <= next_comp;
      diff_float <= next_float;
      spread_amount <= next_spread;
    end
  end

  assign diff_edge_rate = scc_diff_bits(regs[2]); // RL14
  assign diff_amplitude = regs[1][AMP_HI:AMP_LO]; // RL16
  assign ref_slew = regs[3][REF_SLEW_HI:REF_SLEW_LO]; // RL15
  assign ref_enable = regs[3][REF_OE_BIT]; // RL15
  assign ref_wake_on_lan = regs[3][REF_WOL_BIT]; // RL15

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_write_store: assert property (@(posedge mclk) disable iff (!rst_b) // RL3
    (wr_en && wr_idx == IDX_EDGE) |=> (regs[2] == ($past(wr_data) & MASK_EDGE)))
    else $error("edge rate byte did not take written data");
  a_override_stop: assert property (@(posedge mclk) disable iff (!rst_b) // RL10
    (!ovr[0] && stop_state_field == STOP_TRUE_HI && $stable(stop_state_field))
      |=> (!diff_running[0] && diff_true_level[0] && !diff_comp_level[0] && !diff_float[0]))
    else $error("forced-off output does not show the chosen disable state");
  a_spread_select: assert property (@(posedge mclk) disable iff (!rst_b) // RL12
    (!regs[1][SPREAD_SW_CTRL_BIT] && $stable(regs[1]) && $stable(spread_pin_readback))
      |=> (spread_amount == $past(spread_pin_readback)))
    else $error("spread amount ignored the pin while software control off");
  a_edge_reset: assert property (@(posedge mclk) // RL14
    $rose(rst_b) |-> (diff_edge_rate == 6'h3F && ref_slew == 2'h1 && ref_enable
      && !ref_wake_on_lan && diff_amplitude == 2'h2))
    else $error("control fields not at reset values");
  a_readback_read: assert property (@(posedge mclk) disable iff (!rst_b) // RL11
    (rd_idx == IDX_SPREAD && $stable(rd_idx) && $stable(spread_pin_readback))
      |=> (rd_data[7:6] == $past(spread_pin_readback)))
    else $error("readback bits do not show the latched pin level");
endmodule
`default_nettype wire

// ===== core/scc_smbus_target.sv
// smbus target with indexed block read and write over the clock control bytes
// Function
// RL1 - host writes: start, address+write, index N, count X, X data bytes, stop.
// RL2 - device acknowledges address, index, count and each data byte as received.
// RL3 - write data land at indices N through N+X-1 in turn.
// RL4 - host reads: start, address+write, index N, repeated start, address+read.
// RL5 - after acknowledging read address, device first sends the byte count.
// RL6 - then device sends register bytes from index N upward, one per index.
// RL7 - host acknowledges each read byte except the last, then nacks and stops.
// RL8 - bus address taken from select pin, latched, later pin changes ignored.
// RL9 - per-output enable bits reset to 1; 0 forces output to disable state.
// RL10 - disable state: 00 both low, 01 float, 10 true high, 11 complement high.
// RL11 - spread byte bits 7:6 read latched spread pin: 00 low, 01 mid, 11 high.
// RL12 - spread bit 5 resets 0 (pin rules); 1 hands spread to bits 4:3.
// RL13 - software spread: 00 off, 01 -0.25%, 10 reserved, 11 -0.5%.
// RL14 - edge rate byte: one bit per output, 1 fast, 0 slow, reset 1.
// RL15 - reference byte: bit5 wake-on-lan, bit4 enable, bits7:6 slew, reset 01.
// RL16 - spread byte bits 1:0 set differential swing, reset 10.
`default_nettype none
module scc_smbus_target (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_pin,
  input wire logic pwr_good_pin,
  input wire logic [1:0] spread_pin_level,
  input wire logic [5:0] diff_enable_pin_b,
  input wire logic [1:0] stop_state_field,
  output logic [5:0] diff_running,
  output logic [5:0] diff_true_level,
  output logic [5:0] diff_comp_level,
  output logic [5:0] diff_float,
  output logic [5:0] diff_edge_rate,
  output logic [1:0] diff_amplitude,
  output logic [1:0] spread_amount,
  output logic [1:0] ref_slew,
  output logic ref_enable,
  output logic ref_wake_on_lan
);
  import scc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and bus edge detection
  // ----------------------------------------------------------------
  logic [PIN_SYNC_W-1:0] sync1, sync2;
  logic scl_s, sda_s, pg_s, sel_s;
  logic [1:0] spread_s;
  logic [5:0] oe_b_s;
  logic scl_d, sda_d;
  logic start_seen, stop_seen, scl_rise, scl_fall;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // all ones here would fake power good and latch the straps before they are seen
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      sync1 <= {scl_pin, sda_in, pwr_good_pin, address_select_pin, spread_pin_level,
        diff_enable_pin_b};
      sync2 <= sync1;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign {scl_s, sda_s, pg_s, sel_s, spread_s, oe_b_s} = sync2;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;

  // ----------------------------------------------------------------
  // address and spread pin capture at power good
  // ----------------------------------------------------------------
  logic addr_latched, next_addr_latched;
  logic [6:0] target_addr, next_target_addr;
  logic [1:0] spread_latched, next_spread_latched;

  always_comb
  begin
    next_addr_latched = addr_latched;
    next_target_addr = target_addr;
    next_spread_latched = spread_latched;
    // caught once; the pins may be reused after power good
    if (!addr_latched && pg_s)
    begin
      next_addr_latched = 1'b1;
      next_target_addr = sel_s ? TARGET_ADDR_SEL1 : TARGET_ADDR_SEL0; // RL8
      next_spread_latched = spread_s; // RL11
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_latched <= 1'b0;
      target_addr <= TARGET_ADDR_SEL0;
      spread_latched <= 2'h0;
    end
    else
    begin
      addr_latched <= next_addr_latched;
      target_addr <= next_target_addr;
      spread_latched <= next_spread_latched;
    end
  end

  // ----------------------------------------------------------------
  // bus protocol machine
  // ----------------------------------------------------------------
  scc_state_t state, next_state;
  scc_phase_t phase, next_phase;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] txbyte, next_txbyte;
  logic [7:0] ptr, next_ptr;
  logic [7:0] wremain, next_wremain;
  logic rw, next_rw;
  logic host_ack, next_host_ack;
  logic wr_en, next_wr_en;
  logic [7:0] wr_idx, next_wr_idx;
  logic [7:0] wr_data, next_wr_data;
  logic [7:0] rd_data;

  always_comb
  begin
    next_state = state;
    next_phase = phase;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_txbyte = txbyte;
    next_ptr = ptr;
    next_wremain = wremain;
    next_rw = rw;
    next_host_ack = host_ack;
    next_wr_en = 1'b0;
    next_wr_idx = wr_idx;
    next_wr_data = wr_data;
    if (stop_seen)
    begin
      next_state = ST_IDLE;
    end
    else if (start_seen && addr_latched)
    begin
      // a repeated start lands here too, keeping the index for the read
      next_state = ST_RX;
      next_phase = PH_ADDR;
      next_bitcnt = 4'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          next_bitcnt = 4'h0;
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == BITS_PER_BYTE)
          begin
            next_bitcnt = 4'h0;
            next_state = ST_ACK; // RL2
            case (phase)
              PH_ADDR:
              begin
                next_rw = shreg[0];
                if (shreg[7:1] != target_addr)
                begin
                  next_state = ST_IDLE;
                end
              end
              PH_INDEX: next_ptr = shreg;
              PH_COUNT: next_wremain = shreg;
              PH_DATA:
              begin
                // bytes beyond the announced count are acknowledged but dropped
                if (wremain != 8'h00)
                begin
                  next_wr_en = 1'b1; // RL3
                  next_wr_idx = ptr;
                  next_wr_data = shreg;
                  next_ptr = ptr + 8'h01; // RL3
                  next_wremain = wremain - 8'h01;
                end
              end
              default: next_state = ST_IDLE;
            endcase
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            if (phase == PH_ADDR && rw)
            begin
              next_state = ST_TX;
              next_txbyte = READ_BLOCK_COUNT; // RL5
            end
            else
            begin
              next_state = ST_RX;
              case (phase)
                PH_ADDR: next_phase = PH_INDEX;
                PH_INDEX: next_phase = PH_COUNT;
                default: next_phase = PH_DATA;
              endcase
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bitcnt == LAST_TX_BIT)
            begin
              next_state = ST_TXACK;
              next_bitcnt = 4'h0;
            end
            else
            begin
              next_txbyte = {txbyte[6:0], 1'b0};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        ST_TXACK:
        begin
          if (scl_rise)
          begin
            next_host_ack = ~sda_s; // RL7
          end
          else if (scl_fall)
          begin
            if (host_ack)
            begin
              next_state = ST_TX;
              next_txbyte = rd_data; // RL6
              next_ptr = ptr + 8'h01; // RL6
            end
            else
            begin
              next_state = ST_IDLE; // RL7
            end
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      phase <= PH_ADDR;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txbyte <= 8'h00;
      ptr <= 8'h00;
      wremain <= 8'h00;
      rw <= 1'b0;
      host_ack <= 1'b0;
      wr_en <= 1'b0;
      wr_idx <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      txbyte <= next_txbyte;
      ptr <= next_ptr;
      wremain <= next_wremain;
      rw <= next_rw;
      host_ack <= next_host_ack;
      wr_en <= next_wr_en;
      wr_idx <= next_wr_idx;
      wr_data <= next_wr_data;
    end
  end

  // open drain: only ever pulls low, the high level is the bus pull-up
  assign sda_out = 1'b0;
  assign sda_oe = (state == ST_ACK) || (state == ST_TX && !txbyte[7]); // RL2 RL5

  // ----------------------------------------------------------------
  // control bytes
  // ----------------------------------------------------------------
  scc_reg_bank u_bank (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .rd_idx(ptr),
    .rd_data(rd_data),
    .spread_pin_readback(spread_latched),
    .diff_pin_enable(~oe_b_s),
    .stop_state_field(stop_state_field),
    .diff_running(diff_running),
    .diff_true_level(diff_true_level),
    .diff_comp_level(diff_comp_level),
    .diff_float(diff_float),
    .diff_edge_rate(diff_edge_rate),
    .diff_amplitude(diff_amplitude),
    .spread_amount(spread_amount),
    .ref_slew(ref_slew),
    .ref_enable(ref_enable),
    .ref_wake_on_lan(ref_wake_on_lan)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ack_drive: assert property (@(posedge mclk) disable iff (!rst_b) // RL2
    (state == ST_RX && scl_fall && bitcnt == BITS_PER_BYTE && phase != PH_ADDR && !stop_seen
      && !start_seen) |=> (sda_oe && state == ST_ACK))
    else $error("received byte not acknowledged");
  a_count_first: assert property (@(posedge mclk) disable iff (!rst_b) // RL5
    (state == ST_ACK && phase == PH_ADDR && rw && scl_fall && !stop_seen && !start_seen)
      |=> (state == ST_TX && txbyte == READ_BLOCK_COUNT))
    else $error("read did not open with the byte count");
  a_addr_stable: assert property (@(posedge mclk) disable iff (!rst_b) // RL8
    addr_latched |=> (addr_latched && $stable(target_addr)))
    else $error("bus address moved after latching");
  a_ptr_step: assert property (@(posedge mclk) disable iff (!rst_b) // RL6
    (state == ST_TXACK && host_ack && scl_fall && !stop_seen && !start_seen)
      |=> (ptr == $past(ptr) + 8'h01 && txbyte == $past(rd_data)))
    else $error("read did not advance to the next index");
  a_tx_release: assert property (@(posedge mclk) disable iff (!rst_b) // RL7
    (state == ST_TXACK) |-> !sda_oe)
    else $error("device drove the line during host acknowledge");
  a_nack_end: assert property (@(posedge mclk) disable iff (!rst_b) // RL7
    (state == ST_TXACK && !host_ack && scl_fall && !stop_seen && !start_seen)
      |=> (state == ST_IDLE && !sda_oe))
    else $error("device kept sending after the host nack");
endmodule
`default_nettype wire

// ===== test/scc_host_model.sv
// smbus host controller model: drives scl, shares the pulled-up data line
`default_nettype none
module scc_host_model (
  input wire logic mclk,
  input wire logic dev_pull,
  output logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pull = 1'b0;
  // ---------------------------------------------------------------
  // wire and timing
  // ---------------------------------------------------------------
  // pull-up: released line reads high, so no stale value survives
  assign sda = !(pull || dev_pull);
  initial scl = 1'b1;
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // also serves as repeated start: sda released while scl low
  task automatic start();
    pull = 1'b0;
    tk(4);
    scl = 1'b1;
    tk(8);
    pull = 1'b1;
    tk(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    tk(4);
    pull = 1'b1;
    tk(4);
    scl = 1'b1;
    tk(8);
    pull = 1'b0;
    tk(8);
  endtask
  // data changes mid low phase, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    tk(4);
    pull = !b;
    tk(4);
    scl = 1'b1;
    tk(8);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
  // ---------------------------------------------------------------
  // transfers
  // ---------------------------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [7:0] n, input logic [7:0] x,
    input logic [31:0] d, output int acks);
    logic k;
    start();
    wbyte({a, 1'b0}, k);
    acks = int'(k);
    wbyte(n, k);
    acks += int'(k);
    wbyte(x, k);
    acks += int'(k);
    for (int i = 0; i < int'(x); i++)
    begin
      wbyte(d[31-8*i -: 8], k);
      acks += int'(k);
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] n, output logic [39:0] q,
    output int acks);
    logic k;
    start();
    wbyte({a, 1'b0}, k);
    acks = int'(k);
    wbyte(n, k);
    acks += int'(k);
    start();
    wbyte({a, 1'b1}, k);
    acks += int'(k);
    for (int i = 0; i < 5; i++) rbyte(i == 4, q[39-8*i -: 8]);
    stop();
  endtask
endmodule
`default_nettype wire

// ===== test/scc_smbus_target_tb.sv
// testbench for the smbus clock control block
`default_nettype none
module scc_smbus_target_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import scc_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic sel = 1'b1;
  logic pg = 1'b0;
  logic [1:0] ss = 2'h1;
  logic [5:0] en_b = 6'h00;
  logic [1:0] disable_state_select = 2'h0;
  wire scl;
  wire sda;
  logic sda_out, sda_oe, ren, wol;
  logic [5:0] run, tl, cl, fl, er;
  logic [1:0] amp, spr, rsl;
  int errors = 0;
  int comparisons = 0;
  int acks;
  logic [39:0] q;
  always #10 mclk = ~mclk;
  scc_host_model host (.mclk(mclk), .dev_pull(sda_oe), .scl(scl), .sda(sda));
  scc_smbus_target uut (.mclk(mclk), .rst_b(rst_b), .scl_pin(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(sel), .pwr_good_pin(pg),
    .spread_pin_level(ss), .diff_enable_pin_b(en_b), .stop_state_field(disable_state_select),
    .diff_running(run), .diff_true_level(tl), .diff_comp_level(cl), .diff_float(fl),
    .diff_edge_rate(er), .diff_amplitude(amp), .spread_amount(spr), .ref_slew(rsl),
    .ref_enable(ren), .ref_wake_on_lan(wol));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({2'h0, er}, 8'h3F, "edge rate");
    chk({6'h0, amp}, 8'h02, "amplitude");
    chk({4'h0, rsl, wol, ren}, 8'h05, "ref control");
    chk({6'h0, spr}, 8'h00, "spread");
    chk({7'h0, sda_out}, 8'h00, "sda drive value");
    $display("reset test done");
  endtask
  task automatic t_latch();
    pg = 1'b1;
    tk(10);
    sel = 1'b0;
    tk(6);
    chk({2'h0, run}, 8'h3F, "running");
    chk({6'h0, spr}, 8'h01, "pin spread");
    host.wr(TARGET_ADDR_SEL0, 8'h00, 8'h01, 32'h0, acks);
    tk(4);
    chk(8'(acks), 8'h00, "foreign acks");
    chk({2'h0, run}, 8'h3F, "running kept");
    $display("address latch test done");
  endtask
  task automatic t_write();
    host.wr(TARGET_ADDR_SEL1, 8'h00, 8'h04, 32'hDC3801A0, acks);
    tk(4);
    chk(8'(acks), 8'h07, "write acks");
    chk({2'h0, run}, 8'h3E, "override");
    chk({6'h0, spr}, 8'h03, "sw spread");
    chk({6'h0, amp}, 8'h00, "amplitude");
    chk({2'h0, er}, 8'h01, "edge rate");
    chk({4'h0, rsl, wol, ren}, 8'h0A, "ref control");
    $display("block write test done");
  endtask
  task automatic t_stop();
    logic [11:0] st_exp = 12'b010_100_001_000;
    for (int s = 0; s < 4; s++)
    begin
      disable_state_select = 2'(s);
      tk(3);
      chk({5'h0, tl[0], cl[0], fl[0]}, {5'h0, st_exp[3*s +: 3]}, "legs");
    end
    en_b = 6'h20;
    tk(6);
    chk({2'h0, run}, 8'h1E, "pin disable");
    en_b = 6'h00;
    $display("stop state test done");
  endtask
  task automatic t_read();
    host.rd(TARGET_ADDR_SEL1, 8'h00, q, acks);
    chk(8'(acks), 8'h03, "read acks");
    chk(q[39:32], READ_BLOCK_COUNT, "count");
    chk(q[31:24], 8'hDC, "byte 0");
    chk(q[23:16], 8'h78, "byte 1");
    chk(q[15:8], 8'h01, "byte 2");
    chk(q[7:0], 8'hA0, "byte 3");
    $display("block read test done");
  endtask
  task automatic t_spread();
    logic [7:0] v [5] = '{8'h18, 8'h21, 8'h2A, 8'h33, 8'h38};
    logic [3:0] e [5] = '{4'h4, 4'h1, 4'h6, 4'hB, 4'hC};
    for (int i = 0; i < 5; i++)
    begin
      host.wr(TARGET_ADDR_SEL1, 8'h01, 8'h01, {v[i], 24'h0}, acks);
      tk(4);
      chk({4'h0, spr, amp}, {4'h0, e[i]}, "spread amp");
    end
    $display("spread test done");
  endtask
  initial
  begin
    tk(4);
    t_reset();
    tk(4);
    rst_b = 1'b1;
    tk(4);
    t_latch();
    t_write();
    t_stop();
    t_read();
    t_spread();
    wrap_up();
  end
  initial
  begin
    #1000000;
    errors++;
    $display("Error %0t: run timed out", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
